// >>> hbp_pkg.sv
// hbp_pkg: constants shared by the sram-like host bus port
// assumes nothing beyond a systemverilog package scope
package hbp_pkg;

   // address map, word address a[7:1]
   localparam logic [6:0] HBP_FIFO_WIN_BASE = 7'h00;
   localparam logic [6:0] HBP_FIFO_WIN_TOP = 7'h0F;
   localparam logic [6:0] HBP_CSR_BASE = 7'h28;
   localparam logic [6:0] HBP_CSR_TOP = 7'h7F;
   // data-fifo select: only a[2:1] kept; direction picks tx (write) / rx (read)
   localparam int HBP_FIFO_KEEP_BITS = 2;

   // reset values
   localparam logic HBP_RST_BIG_ENDIAN = 1'b0;
   localparam logic HBP_RST_IRQ_POL = 1'b0;
   localparam logic HBP_RST_IRQ_OD = 1'b0;
   localparam logic [7:0] HBP_RST_HOLDOFF = 8'h00;

   // holdoff unit: 10 us in cycles at 20 MHz
   localparam int HBP_CLK_HZ = 20000000;
   localparam int HBP_HOLDOFF_UNIT_NS = 10000;
   localparam int HBP_HOLDOFF_UNIT_CYC =
      (HBP_HOLDOFF_UNIT_NS * (HBP_CLK_HZ / 1000000)) / 1000;

   typedef enum logic [1:0] {
      HBP_IDLE = 2'b00,
      HBP_ACC = 2'b01,
      HBP_DONE = 2'b10
   } hbp_state_t;

endpackage

// >>> hbp_sync_edge.sv
// hbp_sync_edge: registers one strobe and flags its falling edge
// assumes input already synchronous to clk
`timescale 1ns/10ps
module hbp_sync_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic level_n,
   output logic active,
   output logic fall
);
   logic prev_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_ff <= 1'b1;
      end else if (ce) begin
         prev_ff <= level_n;
      end
   end

   assign active = ~level_n;
   assign fall = prev_ff & ~level_n & ce;
endmodule // hbp_sync_edge

// >>> hbp_holdoff.sv
// hbp_holdoff: deassertion interval counter for the interrupt pin
// assumes req is a level from the interrupt sources
`timescale 1ns/10ps
module hbp_holdoff
   import hbp_pkg::*;
#(
   parameter int UNIT_CYC = HBP_HOLDOFF_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic req,
   input wire logic [7:0] interval,
   output logic assert_ok
);
   logic [15:0] unit_ff;
   logic [7:0] left_ff;
   logic was_on_ff;
   logic [15:0] nxt_unit;
   logic [7:0] nxt_left;
   wire logic unit_end = (unit_ff == 16'(UNIT_CYC - 1));
   wire logic fell = was_on_ff & ~req;

   assign nxt_unit = (fell | unit_end) ? 16'h0000 : unit_ff + 16'h0001;
   assign nxt_left = fell ? interval :
      ((left_ff != 8'h00) && unit_end) ? left_ff - 8'h01 : left_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         unit_ff <= 16'h0000;
         left_ff <= 8'h00;
         was_on_ff <= 1'b0;
      end else if (ce) begin
         unit_ff <= nxt_unit;
         left_ff <= nxt_left;
         was_on_ff <= req & (left_ff == 8'h00);
      end
   end

   assign assert_ok = (left_ff == 8'h00) & ~fell;
endmodule // hbp_holdoff

// >>> hbp_host_port.sv
// hbp_host_port: sram-like host port, decode, width and endian steering
// assumes host pins sampled synchronously to clk, fifos/csrs outside
//
// What this block does
// [R01] 16-bit halves assembled to 32-bit words
// [R02] big endian swaps byte lanes
// [R03] seven-bit word address decoded to targets
// [R04] host drives read strobe low to read
// [R05] host drives write strobe low to write
// [R06] strobes count only with chip select
// [R07] write with select wakes reduced power
// [R08] fifo select forces fifo, ignores a[7:3]
// [R09] speed strap latched at reset release
// [R10] upper pull-downs off in 32-bit mode
// [R11] interrupt polarity and open-drain configurable
// [R12] programmable interrupt deassertion interval enforced
// [R13] behaves as async sram, programmed io
// [R14] fifos and csrs share one port
// [R15] bus width strap latched at release
// [R16] drive data only during select and read
`timescale 1ns/10ps
module hbp_host_port
   import hbp_pkg::*;
#(
   parameter int UNIT_CYC = HBP_HOLDOFF_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [6:0] addr,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_select_n,
   input wire logic fifo_sel,
   input wire logic [31:0] data_in,
   output logic [31:0] data_out,
   output logic data_oe_n,
   output logic upper_pulldown_en_ff,
   input wire logic speed_strap,
   input wire logic bus_width_strap,
   output logic speed_100_ff,
   output logic autoneg_en_ff,
   output logic full_duplex_ff,
   output logic bus32_ff,
   input wire logic big_endian,
   input wire logic irq_pol,
   input wire logic irq_od,
   input wire logic [7:0] irq_holdoff,
   input wire logic irq_req,
   output logic irq_out,
   output logic irq_oe_n,
   input wire logic low_power,
   output logic wake_ff,
   output logic [6:0] csr_addr,
   output logic csr_wr,
   output logic csr_rd,
   output logic [31:0] csr_wdata,
   input wire logic [31:0] csr_rdata,
   output logic tx_push,
   output logic [31:0] tx_data,
   output logic rx_pop,
   input wire logic [31:0] rx_data,
   output logic err_unmapped_ff
);
   ////////////////////////////////////////////////////////////////////
   logic rd_act, rd_fall, wr_act, wr_fall;
   logic strap_pend_ff;
   logic [15:0] low_half_ff;
   logic half_hi_ff;
   logic [31:0] rdata_ff;
   logic rd_oe_ff;
   logic [6:0] csr_addr_ff;
   logic csr_wr_ff, csr_rd_ff, tx_push_ff, rx_pop_ff;
   logic [31:0] wdata_ff;
   logic irq_out_ff, irq_oe_n_ff;
   hbp_state_t st_ff, nxt_st;

   hbp_sync_edge u_rd (
      .clk(clk), .rst(rst), .ce(ce), .level_n(read_strobe_n),
      .active(rd_act), .fall(rd_fall)
   );
   hbp_sync_edge u_wr (
      .clk(clk), .rst(rst), .ce(ce), .level_n(write_strobe_n),
      .active(wr_act), .fall(wr_fall)
   );

   ////////////////////////////////////////////////////////////////////
   // [R06] select qualifies strobes
   wire logic cs = ~chip_select_n;
   wire logic rd_go = cs & rd_fall;
   wire logic wr_go = cs & wr_fall;
   // [R08] fifo select hides upper address
   wire logic [6:0] eff_addr = fifo_sel ?
      {5'h00, addr[HBP_FIFO_KEEP_BITS-1:0]} : addr;
   // [R03] word address decode
   wire logic hit_fifo = (eff_addr <= HBP_FIFO_WIN_TOP);
   wire logic hit_csr = (eff_addr >= HBP_CSR_BASE);
   wire logic hit_none = ~hit_fifo & ~hit_csr;
   // [R01] half select: addr[0] is a1 in 16-bit mode
   wire logic hi_half = ~bus32_ff & addr[0];
   wire logic word_done = bus32_ff | hi_half;
   // [R02] byte lane swap
   function automatic logic [31:0] swap32(input logic [31:0] d);
      swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction
   wire logic [31:0] host_word = bus32_ff ? data_in :
      {data_in[15:0], low_half_ff};
   wire logic [31:0] in_word = big_endian ? swap32(host_word) : host_word;
   wire logic [31:0] src_word = hit_fifo ? rx_data : csr_rdata;
   wire logic [31:0] out_word = big_endian ? swap32(src_word) : src_word;
   wire logic [31:0] out_bus = bus32_ff ? out_word :
      {16'h0000, (hi_half ? out_word[31:16] : out_word[15:0])};
   // [R01] low half read pops nothing, high half completes word
   wire logic rd_pop_now = rd_go & hit_fifo & word_done;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         HBP_IDLE: begin
            if (rd_go | wr_go) begin
               nxt_st = HBP_ACC;
            end
         end
         HBP_ACC: begin
            nxt_st = HBP_DONE;
         end
         HBP_DONE: begin
            if (!(cs & (rd_act | wr_act))) begin
               nxt_st = HBP_IDLE;
            end
         end
         default: begin
            nxt_st = HBP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // [R09] [R15] straps caught at first clock after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_pend_ff <= 1'b1;
         speed_100_ff <= 1'b0;
         autoneg_en_ff <= 1'b0;
         full_duplex_ff <= 1'b0;
         bus32_ff <= 1'b0;
         upper_pulldown_en_ff <= 1'b1;
      end else if (ce && strap_pend_ff) begin
         strap_pend_ff <= 1'b0;
         speed_100_ff <= speed_strap;
         autoneg_en_ff <= speed_strap;
         full_duplex_ff <= 1'b0;
         bus32_ff <= bus_width_strap;
         // [R10] pull-downs off when wide
         upper_pulldown_en_ff <= ~bus_width_strap;
      end
   end

   // [R01] [R14] write path: assemble and route
   always_ff @(posedge clk) begin
      if (rst) begin
         low_half_ff <= 16'h0000;
         half_hi_ff <= 1'b0;
         csr_wr_ff <= 1'b0;
         tx_push_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         csr_addr_ff <= 7'h00;
         err_unmapped_ff <= 1'b0;
      end else if (ce) begin
         csr_wr_ff <= wr_go & word_done & hit_csr;
         tx_push_ff <= wr_go & word_done & hit_fifo;
         if (wr_go & ~bus32_ff & ~addr[0]) begin
            low_half_ff <= data_in[15:0];
            half_hi_ff <= 1'b1;
         end
         if (wr_go & word_done) begin
            wdata_ff <= in_word;
            half_hi_ff <= 1'b0;
         end
         if (rd_go | wr_go) begin
            csr_addr_ff <= {eff_addr[6:1], 1'b0};
            err_unmapped_ff <= hit_none;
         end
      end
   end

   // [R13] [R16] read data held while select and read stand
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
         rd_oe_ff <= 1'b0;
         csr_rd_ff <= 1'b0;
         rx_pop_ff <= 1'b0;
         st_ff <= HBP_IDLE;
      end else if (ce) begin
         st_ff <= nxt_st;
         csr_rd_ff <= rd_go & hit_csr;
         rx_pop_ff <= rd_pop_now;
         if (rd_go) begin
            rdata_ff <= hit_none ? 32'h0000_0000 : out_bus;
         end
         rd_oe_ff <= cs & rd_act & ~wr_act;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // [R07] wake on selected write
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_ff <= 1'b0;
      end else if (ce) begin
         wake_ff <= low_power & cs & wr_act;
      end
   end

   // [R12] holdoff gates assertion
   logic irq_ok;
   hbp_holdoff #(.UNIT_CYC(UNIT_CYC)) u_hold (
      .clk(clk), .rst(rst), .ce(ce), .req(irq_req),
      .interval(irq_holdoff), .assert_ok(irq_ok)
   );
   wire logic irq_on = irq_req & irq_ok;

   // [R11] polarity and buffer type
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_out_ff <= 1'b0;
         irq_oe_n_ff <= 1'b1;
      end else if (ce) begin
         irq_out_ff <= irq_od ? 1'b0 : (irq_on ~^ irq_pol);
         irq_oe_n_ff <= irq_od ? ~irq_on : 1'b0;
      end
   end

   assign data_out = rdata_ff;
   assign data_oe_n = ~rd_oe_ff;
   assign irq_out = irq_out_ff;
   assign irq_oe_n = irq_oe_n_ff;
   assign csr_addr = csr_addr_ff;
   assign csr_wr = csr_wr_ff;
   assign csr_rd = csr_rd_ff;
   assign csr_wdata = wdata_ff;
   assign tx_push = tx_push_ff;
   assign tx_data = wdata_ff;
   assign rx_pop = rx_pop_ff;

   ////////////////////////////////////////////////////////////////////
   // assertions
   AST_NO_DRIVE_IDLE: assert property (@(posedge clk) disable iff (rst) // [R16]
      ce && !(cs && rd_act) |=> data_oe_n)
      else $error("data driven without select and read");
   AST_WR_NEEDS_CS: assert property (@(posedge clk) disable iff (rst) // [R06]
      ce && csr_wr |-> $past(!chip_select_n))
      else $error("register write without chip select");
   AST_PUSH_CS: assert property (@(posedge clk) disable iff (rst) // [R06]
      tx_push |-> $past(cs && wr_fall))
      else $error("fifo push without qualified write");
   AST_FIFO_SEL: assert property (@(posedge clk) disable iff (rst) // [R08]
      ce && fifo_sel && wr_go && bus32_ff |=> tx_push && !csr_wr)
      else $error("fifo select did not reach fifo");
   AST_WAKE: assert property (@(posedge clk) disable iff (rst) // [R07]
      ce && low_power && cs && wr_act |=> wake_ff)
      else $error("no wake on selected write");
   AST_PULLDOWN: assert property (@(posedge clk) disable iff (rst) // [R10]
      !strap_pend_ff |-> upper_pulldown_en_ff == !bus32_ff)
      else $error("pull-down state disagrees with width");
   AST_SPEED: assert property (@(posedge clk) disable iff (rst) // [R09]
      !strap_pend_ff |-> speed_100_ff == autoneg_en_ff && !full_duplex_ff)
      else $error("speed defaults inconsistent");
   AST_HALF_NO_PUSH: assert property (@(posedge clk) disable iff (rst) // [R01]
      ce && wr_go && !bus32_ff && !addr[0] |=> !tx_push && !csr_wr)
      else $error("low half completed a word");
   AST_SWAP: assert property (@(posedge clk) disable iff (rst) // [R02]
      ce && wr_go && bus32_ff && big_endian && word_done
      |=> wdata_ff[7:0] == $past(data_in[31:24]))
      else $error("big endian lanes not swapped");
   AST_IRQ_OD: assert property (@(posedge clk) disable iff (rst) // [R11]
      ce && irq_od |=> !irq_out_ff)
      else $error("open-drain output drove high");
   AST_HOLD: assert property (@(posedge clk) disable iff (rst) // [R12]
      ce && irq_on ##1 ce && !irq_req && irq_holdoff != 8'h00
      |=> !irq_on)
      else $error("interrupt asserted inside holdoff");
   AST_DECODE: assert property (@(posedge clk) disable iff (rst) // [R03]
      ce && (rd_go || wr_go) |=> err_unmapped_ff == $past(hit_none))
      else $error("decode flag wrong");
   AST_OE_ON: assert property (@(posedge clk) disable iff (rst) // [R16]
      ce && cs && rd_act && !wr_act |=> !data_oe_n)
      else $error("read data not driven during read");
   AST_RD_STANDS: assert property (@(posedge clk) disable iff (rst) // [R13]
      ce && !rd_go |=> $stable(data_out))
      else $error("read data changed without a read");
   AST_CSR_READ: assert property (@(posedge clk) disable iff (rst) // [R14]
      ce && rd_go && hit_csr |=> csr_rd && !rx_pop)
      else $error("register read not routed");
   AST_FIFO_READ: assert property (@(posedge clk) disable iff (rst) // [R14]
      ce && rd_go && hit_fifo && word_done |=> rx_pop && !csr_rd)
      else $error("fifo read not routed");
   AST_UNMAP_DROP: assert property (@(posedge clk) disable iff (rst) // [R03]
      ce && (rd_go || wr_go) && hit_none
      |=> !csr_wr && !tx_push && !csr_rd && !rx_pop)
      else $error("unmapped access reached a target");
   AST_WIDTH_HELD: assert property (@(posedge clk) disable iff (rst) // [R15]
      !strap_pend_ff && !$past(strap_pend_ff) |-> $stable(bus32_ff))
      else $error("bus width changed after latch");
   AST_PP_OE: assert property (@(posedge clk) disable iff (rst) // [R11]
      ce && !irq_od |=> !irq_oe_n)
      else $error("push-pull interrupt not driven");

   COV_READ32: cover property (@(posedge clk) rd_go && bus32_ff);
   COV_WRITE16: cover property (@(posedge clk) wr_go && !bus32_ff ##[1:20]
      tx_push);
   COV_WAKE: cover property (@(posedge clk) wake_ff);
   COV_IRQ: cover property (@(posedge clk) irq_on);
   COV_HALF: cover property (@(posedge clk) wr_go && hi_half && half_hi_ff);
endmodule // hbp_host_port

// >>> hbp_host_model.sv
// hbp_host_model: embedded host doing programmed io on the port
// assumes the bench calls acc; device samples pins on rising clk
`timescale 1ns/10ps
module hbp_host_model (
   input wire logic clk,
   input wire logic [31:0] data_out,
   output logic [6:0] addr,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_select_n,
   output logic fifo_sel,
   output logic [31:0] data_in
);
   initial begin
      addr = 7'h00;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      fifo_sel = 1'b0;
      data_in = 32'h00000000;
   end
   ////////////////////////////////////////////////////////////////////////
   // strobe within select
   // one access; request held until answer edge, then lines scrambled
   task automatic acc(input logic [6:0] a, input logic [31:0] d,
         input logic fs, input logic rd, input logic cs_n,
         output logic [31:0] q);
      @(posedge clk);
      #1;
      addr = a;
      fifo_sel = fs;
      data_in = d;
      chip_select_n = cs_n;
      read_strobe_n = !rd;
      write_strobe_n = rd;
      repeat (3) @(posedge clk);
      q = data_out;
      #1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      data_in = ~d;
      addr = ~a;
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule // hbp_host_model

// >>> test_hbp_host_port.sv
// test_hbp_host_port: self-checking bench for the host port
// assumes hbp_host_model as host, bench plays csr/fifo back end
`timescale 1ns/10ps
module test_hbp_host_port;
   import hbp_pkg::*;
   localparam int UC = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic speed_strap, bus_width_strap, big_endian, irq_pol, irq_od;
   logic irq_req, low_power;
   logic [7:0] irq_holdoff;
   logic [31:0] csr_rdata, rx_data, data_in, data_out, csr_wdata, tx_data;
   logic [6:0] addr, csr_addr;
   logic read_strobe_n, write_strobe_n, chip_select_n, fifo_sel;
   logic data_oe_n, upper_pulldown_en_ff, speed_100_ff, autoneg_en_ff;
   logic full_duplex_ff, bus32_ff, irq_out, irq_oe_n, wake_ff;
   logic csr_wr, csr_rd, tx_push, rx_pop, err_unmapped_ff;
   int fails = 0;
   int comparisons = 0;
   int n_wr = 0, n_rd = 0, n_tx = 0, n_rx = 0, n_wk = 0, n_oe = 0, n;
   logic [31:0] w_d, t_d, q;
   logic [6:0] w_a;

   hbp_host_port #(.UNIT_CYC(UC)) u_hbp_host_port (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .fifo_sel(fifo_sel),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .upper_pulldown_en_ff(upper_pulldown_en_ff),
      .speed_strap(speed_strap), .bus_width_strap(bus_width_strap),
      .speed_100_ff(speed_100_ff), .autoneg_en_ff(autoneg_en_ff),
      .full_duplex_ff(full_duplex_ff), .bus32_ff(bus32_ff),
      .big_endian(big_endian), .irq_pol(irq_pol), .irq_od(irq_od),
      .irq_holdoff(irq_holdoff), .irq_req(irq_req), .irq_out(irq_out),
      .irq_oe_n(irq_oe_n), .low_power(low_power), .wake_ff(wake_ff),
      .csr_addr(csr_addr), .csr_wr(csr_wr), .csr_rd(csr_rd),
      .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .tx_push(tx_push),
      .tx_data(tx_data), .rx_pop(rx_pop), .rx_data(rx_data),
      .err_unmapped_ff(err_unmapped_ff)
   );
   hbp_host_model u_hbp_host_model (
      .clk(clk), .data_out(data_out), .addr(addr),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .fifo_sel(fifo_sel), .data_in(data_in)
   );

   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // catch one-cycle pulses on the back end
   always @(posedge clk) begin
      if (csr_wr === 1'b1) begin
         n_wr++;
         w_a = csr_addr;
         w_d = csr_wdata;
      end
      if (tx_push === 1'b1) begin
         n_tx++;
         t_d = tx_data;
      end
      if (csr_rd === 1'b1) n_rd++;
      if (rx_pop === 1'b1) n_rx++;
      if (wake_ff === 1'b1) n_wk++;
      if (data_oe_n === 1'b0) n_oe++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // straps flipped after the latch edge to prove they are held
   task automatic do_rst(input logic sp, input logic bw);
      @(posedge clk);
      #1;
      rst = 1'b1;
      speed_strap = sp;
      bus_width_strap = bw;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      speed_strap = !sp;
      bus_width_strap = !bw;
      repeat (2) @(posedge clk);
      #1;
      chk("speed", sp, speed_100_ff);
      chk("autoneg", sp, autoneg_en_ff);
      chk("duplex", 1'b0, full_duplex_ff);
      chk("bus32", bw, bus32_ff);
      chk("pulldown", !bw, upper_pulldown_en_ff);
   endtask

   task automatic wait_irq(input logic v);
      n = 0;
      while (irq_out !== v && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {big_endian, irq_pol, irq_od, irq_req, low_power} = 5'h00;
      irq_holdoff = 8'h01;
      csr_rdata = 32'h0BADBEEF;
      rx_data = 32'hCAFEF00D;
      do_rst(1'b1, 1'b1);
      u_hbp_host_model.acc(7'h28, 32'h11223344, 1'b0, 1'b0, 1'b0, q);
      chk("wr_cnt", 1, n_wr);
      chk("wr_addr", 7'h28, w_a);
      chk("wr_data", 32'h11223344, w_d);
      chk("oe_after_wr", 0, n_oe);
      u_hbp_host_model.acc(7'h28, 32'h55555555, 1'b0, 1'b0, 1'b1, q);
      chk("unselected", 1, n_wr);
      u_hbp_host_model.acc(7'h7C, 32'hA5A55A5A, 1'b1, 1'b0, 1'b0, q);
      chk("tx_cnt", 1, n_tx);
      chk("tx_data", 32'hA5A55A5A, t_d);
      chk("fifo_not_csr", 1, n_wr);
      u_hbp_host_model.acc(7'h7F, 32'h00000000, 1'b1, 1'b1, 1'b0, q);
      chk("rx_cnt", 1, n_rx);
      chk("rx_data", 32'hCAFEF00D, q);
      chk("oe_idle", 1'b1, data_oe_n);
      chk("oe_read", 1, (n_oe > 0));
      u_hbp_host_model.acc(7'h30, 32'h00000000, 1'b0, 1'b1, 1'b0, q);
      chk("rd_cnt", 1, n_rd);
      chk("rd_data", 32'h0BADBEEF, q);
      u_hbp_host_model.acc(7'h10, 32'h00000000, 1'b0, 1'b1, 1'b0, q);
      chk("unmapped", 32'h00000000, q);
      chk("unmapped_err", 1'b1, err_unmapped_ff);
      chk("no_wake", 0, n_wk);
      big_endian = 1'b1;
      u_hbp_host_model.acc(7'h28, 32'h11223344, 1'b0, 1'b0, 1'b0, q);
      chk("endian", 32'h44332211, w_d);
      big_endian = 1'b0;
      low_power = 1'b1;
      u_hbp_host_model.acc(7'h28, 32'h00000001, 1'b0, 1'b0, 1'b0, q);
      chk("wake", 1, (n_wk > 0));
      low_power = 1'b0;
      do_rst(1'b0, 1'b0);
      n_wr = 0;
      u_hbp_host_model.acc(7'h28, 32'hFFFF3344, 1'b0, 1'b0, 1'b0, q);
      chk("half_wait", 0, n_wr);
      u_hbp_host_model.acc(7'h29, 32'hFFFF1122, 1'b0, 1'b0, 1'b0, q);
      chk("half_cnt", 1, n_wr);
      chk("half_word", 32'h11223344, w_d);
      u_hbp_host_model.acc(7'h00, 32'hFFFF5566, 1'b0, 1'b0, 1'b0, q);
      u_hbp_host_model.acc(7'h01, 32'hFFFF7788, 1'b0, 1'b0, 1'b0, q);
      chk("half_tx", 32'h77885566, t_d);
      chk("half_tx_cnt", 2, n_tx);
      u_hbp_host_model.acc(7'h00, 32'h00000000, 1'b0, 1'b1, 1'b0, q);
      chk("half_rd_lo", 32'h0000F00D, q);
      chk("half_rd_wait", 1, n_rx);
      u_hbp_host_model.acc(7'h01, 32'h00000000, 1'b0, 1'b1, 1'b0, q);
      chk("half_rd_hi", 32'h0000CAFE, q);
      chk("half_rd_pop", 2, n_rx);
      irq_pol = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("irq_hi_idle", 1'b0, irq_out);
      irq_req = 1'b1;
      wait_irq(1'b1);
      chk("irq_high", 1'b1, irq_out);
      chk("irq_pp_oe", 1'b0, irq_oe_n);
      irq_od = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("irq_od_out", 1'b0, irq_out);
      chk("irq_od_on", 1'b0, irq_oe_n);
      irq_req = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("irq_od_off", 1'b1, irq_oe_n);
      irq_od = 1'b0;
      irq_req = 1'b1;
      wait_irq(1'b1);
      irq_req = 1'b0;
      wait_irq(1'b0);
      irq_req = 1'b1;
      wait_irq(1'b1);
      chk("holdoff", 1, (n >= UC && n < 40));
      irq_pol = 1'b0;
      irq_req = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("irq_low_idle", 1'b1, irq_out);
      irq_req = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("irq_low_act", 1'b0, irq_out);
      end_sim();
   end

   initial begin
      #(50 * 3000);
      fails++;
      end_sim();
   end
endmodule // test_hbp_host_port
